/* File: common/tsp_pkg.sv */
// Package for the serial port pin control block: constants and carriers.
// Assumes a 20 MHz system clock; all serial pins are sampled by it.
package tsp_pkg;

	// ----------------------------------------
	// Clock and timing
	// ----------------------------------------
	localparam int SYS_CLK_HZ     = 20000000;
	localparam int BCLK_MIN_HZ    = 512000;
	localparam int BCLK_MAX_HZ    = 8192000;
	// Half period of a generated bit clock, in system cycles (rounded down)
	localparam int GEN_HALF_CYC   = SYS_CLK_HZ / (2 * BCLK_MIN_HZ);
	localparam int DIV_W          = 8;
	localparam logic [DIV_W-1:0] DIV_RESET = 8'h00;

	// ----------------------------------------
	// Frame layout
	// ----------------------------------------
	localparam int FRAME_BITS     = 32;
	localparam int CNT_W          = 5;
	localparam logic [CNT_W-1:0] CNT_RESET = 5'h00;
	localparam logic [CNT_W-1:0] CNT_LAST  = 5'h1f;
	localparam logic [31:0] WORD_RESET     = 32'h0000_0000;

	// Pin directions
	typedef enum logic { TSP_DIR_IN, TSP_DIR_OUT } tsp_dir_t;
	// Launch or sample edge
	typedef enum logic { TSP_EDGE_RISE, TSP_EDGE_FALL } tsp_edge_t;

	// Configuration carrier
	typedef struct packed {
		tsp_dir_t  txSyncDir;
		tsp_dir_t  txClkDir;
		tsp_dir_t  rxSyncDir;
		tsp_dir_t  rxClkDir;
		tsp_edge_t txEdge;
		tsp_edge_t rxEdge;
	} tsp_cfg_t;

	localparam tsp_cfg_t CFG_RESET = '{TSP_DIR_IN, TSP_DIR_IN, TSP_DIR_IN, TSP_DIR_IN,
		TSP_EDGE_RISE, TSP_EDGE_RISE};

	// Two-way pin carrier
	typedef struct packed {
		logic o;
		logic oe;
	} tsp_pin_t;

endpackage : tsp_pkg

/* File: hw/tsp_pin_ctrl.sv */
// Serial port pin control: sync/clock pin directions, open-drain data, edge choice.
// Assumes pins arrive asynchronously; bit clocks are far slower than clk.
`timescale 1ns/1ps

module tsp_pin_ctrl (
	// System
	input  wire logic             clk,
	input  wire logic             rst,
	// Configuration
	input  wire tsp_pkg::tsp_cfg_t cfg,
	// Transmit word, loaded at each frame start
	input  wire logic [31:0]      txWord,
	output logic                  txLoad,
	// Receive word, completed at frame end
	output logic [31:0]           rxWord,
	output logic                  rxValid,
	// Transmit pins
	input  wire logic             txSyncIn,
	output tsp_pkg::tsp_pin_t     txSyncPin,
	input  wire logic             txClkIn,
	output tsp_pkg::tsp_pin_t     txClkPin,
	output tsp_pkg::tsp_pin_t     txDataPin,
	// Receive pins
	input  wire logic             rxSyncIn,
	output tsp_pkg::tsp_pin_t     rxSyncPin,
	input  wire logic             rxClkIn,
	output tsp_pkg::tsp_pin_t     rxClkPin,
	input  wire logic             rxDataIn
);
	import tsp_pkg::*;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [4:0] syncA;
	logic [4:0] syncB;
	logic [4:0] next_syncA;
	logic [4:0] next_syncB;
	logic       txClkPrev;
	logic       rxClkPrev;
	logic       next_txClkPrev;
	logic       next_rxClkPrev;
	logic       txClkLvl;
	logic       rxClkLvl;

	always_comb
	begin
		next_syncA     = {rxDataIn, rxSyncIn, rxClkIn, txSyncIn, txClkIn};
		next_syncB     = syncA;
		next_txClkPrev = txClkLvl;
		next_rxClkPrev = rxClkLvl;
	end

	// No reset: edge history tracks idle pin levels, so no false edge on release
	always_ff @(posedge clk)
	begin
		syncA     <= next_syncA;
		syncB     <= next_syncB;
		txClkPrev <= next_txClkPrev;
		rxClkPrev <= next_rxClkPrev;
	end

	// ----------------------------------------
	// Bit clock generation
	// ----------------------------------------
	// One divider serves both ports; generated rate is just above the lowest legal one
	logic [DIV_W-1:0] divCnt;
	logic [DIV_W-1:0] next_divCnt;
	logic             genClk;
	logic             next_genClk;

	always_comb
	begin
		if (divCnt == DIV_W'(GEN_HALF_CYC - 1))
		begin
			next_divCnt = DIV_RESET;
			next_genClk = ~genClk;
		end
		else
		begin
			next_divCnt = divCnt + 8'h01;
			next_genClk = genClk;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			divCnt <= DIV_RESET;
			genClk <= 1'b0;
		end
		else
		begin
			divCnt <= next_divCnt;
			genClk <= next_genClk;
		end
	end

	assign txClkLvl = (cfg.txClkDir == TSP_DIR_OUT) ? genClk : syncB[0];
	assign rxClkLvl = (cfg.rxClkDir == TSP_DIR_OUT) ? genClk : syncB[2];
	// Pins stay inputs while reset is held, whatever the configuration
	assign txClkPin = '{o: genClk, oe: (cfg.txClkDir == TSP_DIR_OUT) && !rst};
	assign rxClkPin = '{o: genClk, oe: (cfg.rxClkDir == TSP_DIR_OUT) && !rst};

	logic txLaunch;
	logic rxSample;
	assign txLaunch = (cfg.txEdge == TSP_EDGE_RISE) ? (txClkLvl & ~txClkPrev)
		: (~txClkLvl & txClkPrev);
	assign rxSample = (cfg.rxEdge == TSP_EDGE_RISE) ? (rxClkLvl & ~rxClkPrev)
		: (~rxClkLvl & rxClkPrev);

	// ----------------------------------------
	// Transmit side
	// ----------------------------------------
	logic [CNT_W-1:0] txCnt;
	logic [CNT_W-1:0] next_txCnt;
	logic [31:0]      txShift;
	logic [31:0]      next_txShift;
	logic             txSyncOut;
	logic             next_txSyncOut;
	logic             txBit;
	logic             next_txBit;
	logic             txStart;

	always_comb
	begin
		next_txCnt     = txCnt;
		next_txShift   = txShift;
		next_txSyncOut = txSyncOut;
		next_txBit     = txBit;
		txStart        = 1'b0;
		if (txLaunch)
		begin
			// align to input sync or own count
			if (cfg.txSyncDir == TSP_DIR_IN)
				txStart = syncB[1];
			else
				txStart = (txCnt == CNT_LAST);
			if (txStart)
			begin
				next_txBit   = txWord[31];
				next_txShift = {txWord[30:0], 1'b1};
				next_txCnt   = CNT_RESET;
			end
			else
			begin
				next_txBit   = txShift[31];
				next_txShift = {txShift[30:0], 1'b1};
				next_txCnt   = txCnt + 5'h01;
			end
			next_txSyncOut = txStart && (cfg.txSyncDir == TSP_DIR_OUT);
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			txCnt     <= CNT_LAST;
			txShift   <= WORD_RESET;
			txSyncOut <= 1'b0;
			txBit     <= 1'b1;
		end
		else
		begin
			txCnt     <= next_txCnt;
			txShift   <= next_txShift;
			txSyncOut <= next_txSyncOut;
			txBit     <= next_txBit;
		end
	end

	assign txLoad = txLaunch & txStart;
	assign txSyncPin = '{o: txSyncOut, oe: (cfg.txSyncDir == TSP_DIR_OUT) && !rst};
	assign txDataPin = '{o: 1'b0, oe: ~txBit};

	// ----------------------------------------
	// Receive side
	// ----------------------------------------
	logic [CNT_W-1:0] rxCnt;
	logic [CNT_W-1:0] next_rxCnt;
	logic [31:0]      rxShift;
	logic [31:0]      next_rxShift;
	logic [31:0]      next_rxWord;
	logic             next_rxValid;
	logic             rxSyncOut;
	logic             next_rxSyncOut;
	logic             rxStart;

	always_comb
	begin
		next_rxCnt     = rxCnt;
		next_rxShift   = rxShift;
		next_rxWord    = rxWord;
		next_rxValid   = 1'b0;
		next_rxSyncOut = rxSyncOut;
		rxStart        = 1'b0;
		if (rxSample)
		begin
			if (cfg.rxSyncDir == TSP_DIR_IN)
				rxStart = syncB[3];
			else
				rxStart = (rxCnt == CNT_LAST);
			next_rxCnt   = rxStart ? CNT_RESET : rxCnt + 5'h01;
			next_rxShift = {rxShift[30:0], syncB[4]};
			// Word completes on last bit of frame
			if (next_rxCnt == CNT_LAST)
			begin
				next_rxWord  = {rxShift[30:0], syncB[4]};
				next_rxValid = 1'b1;
			end
			next_rxSyncOut = rxStart && (cfg.rxSyncDir == TSP_DIR_OUT);
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			rxCnt     <= CNT_LAST;
			rxShift   <= WORD_RESET;
			rxWord    <= WORD_RESET;
			rxValid   <= 1'b0;
			rxSyncOut <= 1'b0;
		end
		else
		begin
			rxCnt     <= next_rxCnt;
			rxShift   <= next_rxShift;
			rxWord    <= next_rxWord;
			rxValid   <= next_rxValid;
			rxSyncOut <= next_rxSyncOut;
		end
	end

	assign rxSyncPin = '{o: rxSyncOut, oe: (cfg.rxSyncDir == TSP_DIR_OUT) && !rst};

endmodule : tsp_pin_ctrl

/* File: bench/tsp_chk_sva.sv */
// Checker on the serial port pin control ports.
// Assumes one clock domain and static configuration.
`timescale 1ns/1ps
module tsp_chk (
	// System
	input wire logic              clk,
	input wire logic              rst,
	input wire tsp_pkg::tsp_cfg_t cfg,
	// Transmit
	input wire logic [31:0]       txWord,
	input wire logic              txLoad,
	input wire tsp_pkg::tsp_pin_t txSyncPin,
	input wire tsp_pkg::tsp_pin_t txClkPin,
	input wire tsp_pkg::tsp_pin_t txDataPin,
	// Receive
	input wire logic              rxValid,
	input wire tsp_pkg::tsp_pin_t rxSyncPin,
	input wire tsp_pkg::tsp_pin_t rxClkPin
);
	import tsp_pkg::*;
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	tx_sync_dir_a: assert property (!$past(rst) && $stable(cfg) |->
		txSyncPin.oe == cfg.txSyncDir) else $error("tx sync direction wrong");
	tx_clk_dir_a: assert property (!$past(rst) && $stable(cfg) |->
		txClkPin.oe == cfg.txClkDir) else $error("tx clock direction wrong");
	rx_sync_dir_a: assert property (!$past(rst) && $stable(cfg) |->
		rxSyncPin.oe == cfg.rxSyncDir) else $error("rx sync direction wrong");
	rx_clk_dir_a: assert property (!$past(rst) && $stable(cfg) |->
		rxClkPin.oe == cfg.rxClkDir) else $error("rx clock direction wrong");
	data_od_a: assert property (txDataPin.o == 1'b0)
		else $error("data pin driven high");
	frame_load_a: assert property (txLoad && cfg.txSyncDir == TSP_DIR_OUT |=>
		txSyncPin.o && txDataPin.oe == !$past(txWord[31])) else $error("bad frame start");
	gen_clk_a: assert property (txClkPin.oe && $changed(txClkPin.o) |=>
		$stable(txClkPin.o) [*8] ##1 $stable(txClkPin.o) [*8] ##1 $stable(txClkPin.o) [*2]
		##1 $changed(txClkPin.o)) else $error("clock period");
	rx_pulse_a: assert property (rxValid |=> !rxValid)
		else $error("rx valid too long");
endmodule : tsp_chk

bind tsp_pin_ctrl tsp_chk u_chk (.clk, .rst, .cfg, .txWord, .txLoad, .txSyncPin, .txClkPin,
	.txDataPin, .rxValid, .rxSyncPin, .rxClkPin);

/* File: bench/tsp_far_end.sv */
// Far-end framer: bit clock, frame sync and receive data.
// Assumes launch and sample edges share one edge choice.
`timescale 1ns/1ps
module tsp_far_end (
	// System
	input wire logic clk,
	// Link
	input wire logic edgeSel,
	input wire logic txLine,
	input wire logic txSync,
	input wire logic extSync,
	output logic     bclk,
	output logic     sync,
	output logic     data
);
	logic [31:0] shift;
	int          cnt = 99;
	logic [31:0] gotTx [$];
	initial
	begin
		bclk = 1'b0;
		sync = 1'b0;
		data = 1'b0;
	end
	// Sampled just before the next launch, far from the change
	// Own sync rises with the device's bit 0, on the same launch edge
	function automatic void grab(input int i);
		if (extSync ? (i == 2) : txSync)
			cnt = 0;
		if (cnt < 32)
		begin
			shift = {shift[30:0], txLine};
			cnt++;
			if (cnt == 32)
				gotTx.push_back(shift);
		end
	endfunction : grab
	// 400 ns period, still between frames
	task automatic frame(input logic [31:0] w);
		@(posedge clk);
		bclk <= edgeSel;
		repeat (4) @(posedge clk);
		for (int i = 0; i <= 32; i++)
		begin
			bclk <= !edgeSel;
			grab(i);
			repeat (4) @(posedge clk);
			bclk <= edgeSel;
			sync <= (i == 0);
			data <= (i < 32) ? w[31-i] : !data;
			repeat (4) @(posedge clk);
		end
	endtask : frame
endmodule : tsp_far_end

/* File: bench/tb_top.sv */
// Self-checking bench for the serial port pin control block.
// Assumes the far-end model and the bound checker.
`timescale 1ns/1ps
module tb_top;
	import tsp_pkg::*;
	logic        clk, rst, txLoad, rxValid, bclk, sync, data;
	tsp_cfg_t    cfg;
	logic [31:0] txWord, rxWord;
	tsp_pin_t    txSyncPin, txClkPin, txDataPin, rxSyncPin, rxClkPin;
	int          fails = 0, checkCount = 0, seed = 32'haedf, half;
	realtime     t0;
	logic [31:0] txQ [$], rxQ [$];
	// Pull-up on the data line
	wire txLine  = !txDataPin.oe;
	wire txClkW  = txClkPin.oe ? txClkPin.o : bclk;
	wire rxClkW  = rxClkPin.oe ? rxClkPin.o : bclk;
	wire txSyncW = txSyncPin.oe ? txSyncPin.o : sync;
	wire rxSyncW = rxSyncPin.oe ? rxSyncPin.o : sync;
	tsp_pin_ctrl dut (.clk, .rst, .cfg, .txWord, .txLoad, .rxWord, .rxValid, .txSyncIn(txSyncW),
		.txSyncPin, .txClkIn(txClkW), .txClkPin, .txDataPin, .rxSyncIn(rxSyncW), .rxSyncPin,
		.rxClkIn(rxClkW), .rxClkPin, .rxDataIn(data));
	tsp_far_end far (.clk, .edgeSel(cfg.txEdge), .txLine, .txSync(txSyncPin.o),
		.extSync(cfg.txSyncDir == TSP_DIR_IN), .bclk, .sync, .data);
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic check(input string what, input logic [31:0] exp, got);
		checkCount++;
		if (got !== exp)
		begin
			fails++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic printVerdict();
		$display("checks %0d mismatches %0d", checkCount, fails);
		if (fails == 0 && checkCount > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : printVerdict
	task automatic restart(input tsp_cfg_t c);
		rst <= 1'b1;
		cfg <= c;
		repeat (8) @(posedge clk);
		check("oeInReset", 0, {txSyncPin.oe, txClkPin.oe, rxSyncPin.oe, rxClkPin.oe});
		check("resetOut", 0, {txDataPin.oe, rxValid});
		check("resetWord", 0, rxWord);
		txQ.delete();
		rxQ.delete();
		far.gotTx.delete();
		far.cnt = 99;
		rst <= 1'b0;
	endtask : restart
	// ----------------------------------------
	// Reference model
	// ----------------------------------------
	always @(posedge clk)
	begin
		if (txLoad && !rst)
		begin
			txQ.push_back(txWord);
			txWord <= $random(seed);
		end
		if (rxValid && cfg.rxSyncDir == TSP_DIR_IN)
			check("rxWord", rxQ.pop_front(), rxWord);
	end
	initial
	begin
		rst = 1'b1;
		cfg = CFG_RESET;
		txWord = 32'h0;
		// Own and external transmit sync, each on both edges
		for (int e = 0; e < 4; e++)
		begin
			restart('{tsp_dir_t'(e < 2), TSP_DIR_IN, TSP_DIR_IN, TSP_DIR_IN, tsp_edge_t'(e % 2),
				tsp_edge_t'(e % 2)});
			repeat (3)
			begin
				rxQ.push_back($random(seed));
				far.frame(rxQ[$]);
			end
			check("txFrames", 1, far.gotTx.size() > 1);
			foreach (far.gotTx[k]) check("txFrame", txQ[k], far.gotTx[k]);
		end
		restart('{TSP_DIR_OUT, TSP_DIR_OUT, TSP_DIR_OUT, TSP_DIR_OUT, TSP_EDGE_FALL,
			TSP_EDGE_RISE});
		repeat (3) @(posedge clk);
		check("oeOut", 4'hf, {txSyncPin.oe, txClkPin.oe, rxSyncPin.oe, rxClkPin.oe});
		@(txClkPin.o) t0 = $realtime;
		@(txClkPin.o) half = int'(($realtime - t0) / 50);
		check("halfPeriod", GEN_HALF_CYC, half);
		check("clkRange", 1, SYS_CLK_HZ / (2 * half) inside {[BCLK_MIN_HZ:BCLK_MAX_HZ]});
		@(posedge txSyncPin.o) t0 = $realtime;
		@(posedge txSyncPin.o) half = int'(($realtime - t0) / 50);
		check("syncGap", FRAME_BITS * 2 * GEN_HALF_CYC, half);
		@(rxClkPin.o) t0 = $realtime;
		@(rxClkPin.o) half = int'(($realtime - t0) / 50);
		check("rxHalfPeriod", GEN_HALF_CYC, half);
		@(posedge rxSyncPin.o) t0 = $realtime;
		@(posedge rxSyncPin.o) half = int'(($realtime - t0) / 50);
		check("rxSyncGap", FRAME_BITS * 2 * GEN_HALF_CYC, half);
		printVerdict();
	end
	initial
	begin
		#2000000;
		fails++;
		printVerdict();
	end
endmodule : tb_top
